//--- include/dmx_pkg.sv
// Notes on behaviour
// RULE1: Lower RAM 00h-7Fh, direct or indirect
// RULE2: Bottom 32 bytes are four eight-register banks
// RULE3: Bank select picks 00h, 08h, 10h, 18h
// RULE4: Bytes 20h-2Fh hold bits 00h-7Fh
// RULE5: Upper RAM 80h-FFh by indirect only
// RULE6: Direct 80h-FFh goes to special registers
// RULE7: On-chip expanded memory 0000h-03FFh, movx only
// RULE8: Select bit 0 on-chip, 1 external
// RULE9: Two-bit size field, default full size
// RULE10: Size codes give 256/512/768/1024 bytes
// RULE11: Beyond configured size goes external
// RULE12: Low address/data on port 0, high on port 2
// RULE13: Latch strobe marks valid low address
// RULE14: Active-low read strobe, partner drives data
// RULE15: Active-low write strobe with data driven
// RULE16: External cycle lasts six CPU clocks
// RULE17: Stretch bit widens strobes 3 to 15
// RULE18: Pointer-register movx keeps port 2 latch
// RULE19: Latch strobe free-running unless disabled
package dmx_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PSW = 8'h00;
  localparam logic [7:0] OFS_AUX = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_WDAT = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_PORT2 = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Field positions
  localparam int PSW_BANK_LO = 3;
  localparam int AUX_DIS = 0;
  localparam int AUX_EXT = 1;
  localparam int AUX_SIZE_LO = 2;
  localparam int AUX_STRETCH = 5;
  localparam int CMD_WR = 3;
  // Values after reset
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h0C;
  localparam logic [7:0] PORT2_RST = 8'hFF;
  // Cycle counts, in CPU clocks
  localparam logic [3:0] STB_NORM = 4'h3;
  localparam logic [3:0] STB_SLOW = 4'hF;
  localparam logic [1:0] ALE_DIV_LAST = 2'h2;
  // Memory geometry
  localparam int IRAM_AW = 8;
  localparam int EXPANDED_ON_CHIP_MEMORY_AW = 10;
  // AXI responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;
  // Access kinds written to the command register
  typedef enum logic [2:0] {
    K_DIRECT, K_INDIRECT, K_BANK, K_BIT, K_MOVX_RI, K_MOVX_DPTR
  } dmx_kind_type;
  // Where an access lands
  typedef enum logic [1:0] {T_IRAM, T_SFR, T_EXPANDED_ON_CHIP_MEMORY, T_EXT} dmx_tgt_type;
endpackage

//--- logic/dmx_ale_gen.sv
`timescale 1ns/1ps
`default_nettype none
module dmx_ale_gen import dmx_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // One-cycle pulse every third CPU clock
  output logic pulse_q
);
  typedef struct packed {
    logic [1:0] cnt;
    logic pulse;
  } dmx_ale_type;
  dmx_ale_type r_q, r_d;
  assign pulse_q = r_q.pulse;
  // Divide by three: one sixth of the oscillator in either speed mode
  always_comb begin
    r_d = r_q;
    r_d.cnt = (r_q.cnt == ALE_DIV_LAST) ? 2'h0 : r_q.cnt + 2'h1;
    r_d.pulse = (r_q.cnt == ALE_DIV_LAST);
    if (!rstn) begin
      r_d = '0;
    end
  end
  // State register
  always_ff @(posedge sys_clk) begin
    r_q <= r_d;
  end
endmodule
`default_nettype wire

//--- logic/dmx_core.sv
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dmx_core import dmx_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Special function register segment
  output logic [7:0] sfr_addr_q,
  output logic sfr_rd_q,
  output logic sfr_wr_q,
  output logic [7:0] sfr_wdata_q,
  input wire logic [7:0] sfr_rdata,
  // External multiplexed bus
  input wire logic [7:0] muxed_low_addr_data_in,
  output logic [7:0] muxed_low_addr_data_out_q,
  output logic muxed_low_addr_data_oe_q,
  output logic [7:0] upper_address_lines_q,
  output logic ale_q,
  output logic rd_n_q,
  output logic wr_n_q
);
  typedef enum logic [2:0] {
    S_IDLE, S_IRD1, S_IRD2, S_XADR, S_XLAT, S_XSTB, S_XEND
  } dmx_state_type;
  typedef struct packed {
    logic awv;            // Write address held
    logic [7:0] awa;
    logic wv;             // Write data held
    logic [31:0] wd;
    logic [3:0] ws;
    logic awr, wr_rdy, arr;
    logic bv;
    logic [1:0] bresp;
    logic rv;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] program_status_word;      // Program status word copy
    logic [7:0] aux;      // Memory control bits
    logic [15:0] addr;    // Access address
    logic [7:0] wdat;     // Access write byte
    logic [7:0] port2;    // Port 2 latch content
    dmx_kind_type kind;
    logic wr;
    logic slow;           // Stretch latched at start
    dmx_state_type st;
    dmx_tgt_type tgt;
    logic [7:0] rdat;
    logic [2:0] bitn;
    logic [3:0] cnt;
    logic [9:0] ma;       // Memory address
    logic [7:0] mwd;
    logic iwe, xwe;
    logic [7:0] sa;
    logic sre, swe;
    logic [7:0] p0o;
    logic p0oe;
    logic [7:0] p2o;
    logic ale, rdn, wrn;
  } dmx_regs_type;
  dmx_regs_type r_q, r_d;
  logic [7:0] iram_rd, expanded_on_chip_memory_rd;
  logic ale_pulse;
  logic [15:0] xa;

  // Replace one bit of a byte
  function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] n,
                                         input logic v);
    logic [7:0] o;
    o = b;
    o[n] = v;
    return o;
  endfunction

  // Internal RAM: lower and upper 128 bytes
  dmx_mem #(.AW(IRAM_AW)) u_iram (
    .sys_clk(sys_clk), .addr(r_q.ma[7:0]), .we(r_q.iwe), .wd(r_q.mwd), .rd_q(iram_rd)
  );
  // On-chip expanded memory, 1024 bytes
  dmx_mem #(.AW(EXPANDED_ON_CHIP_MEMORY_AW)) u_expanded_on_chip_memory (
    .sys_clk(sys_clk), .addr(r_q.ma), .we(r_q.xwe), .wd(r_q.mwd), .rd_q(expanded_on_chip_memory_rd)
  );
  // Free-running latch strobe timebase
  dmx_ale_gen u_ale (.sys_clk(sys_clk), .rstn(rstn), .pulse_q(ale_pulse));

  // Outputs straight from the state register
  assign s_axi_awready = r_q.awr;
  assign s_axi_wready = r_q.wr_rdy;
  assign s_axi_bvalid = r_q.bv;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_arready = r_q.arr;
  assign s_axi_rvalid = r_q.rv;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;
  assign sfr_addr_q = r_q.sa;
  assign sfr_rd_q = r_q.sre;
  assign sfr_wr_q = r_q.swe;
  assign sfr_wdata_q = r_q.mwd;
  assign muxed_low_addr_data_out_q = r_q.p0o;
  assign muxed_low_addr_data_oe_q = r_q.p0oe;
  assign upper_address_lines_q = r_q.p2o;
  assign ale_q = r_q.ale;
  assign rd_n_q = r_q.rdn;
  assign wr_n_q = r_q.wrn;

  // Next state: bus slave, access decode and bus sequencer
  always_comb begin
    r_d = r_q;
    xa = 16'h0000;
    r_d.iwe = 1'b0;
    r_d.xwe = 1'b0;
    r_d.sre = 1'b0;
    r_d.swe = 1'b0;
    // Response handshakes retire
    if (r_q.bv && s_axi_bready) begin
      r_d.bv = 1'b0;
    end
    if (r_q.rv && s_axi_rready) begin
      r_d.rv = 1'b0;
    end
    // Take address and data in either order
    if (s_axi_awvalid && r_q.awr) begin
      r_d.awv = 1'b1;
      r_d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_q.wr_rdy) begin
      r_d.wv = 1'b1;
      r_d.wd = s_axi_wdata;
      r_d.ws = s_axi_wstrb;
    end
    // Register read
    if (s_axi_arvalid && r_q.arr) begin
      r_d.rv = 1'b1;
      r_d.rresp = RESP_OK;
      r_d.rdata = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_PSW: r_d.rdata[7:0] = r_q.program_status_word;
        OFS_AUX: r_d.rdata[7:0] = r_q.aux;
        OFS_ADDR: r_d.rdata[15:0] = r_q.addr;
        OFS_WDAT: r_d.rdata[7:0] = r_q.wdat;
        OFS_CMD: r_d.rdata[3:0] = {r_q.wr, r_q.kind};
        OFS_PORT2: r_d.rdata[7:0] = r_q.port2;
        OFS_STAT: r_d.rdata[15:0] = {r_q.rdat, 4'h0, r_q.rdat[r_q.bitn], r_q.tgt,
                                     r_q.st != S_IDLE};
        default: r_d.rresp = RESP_DEC;
      endcase
    end
    // Register write once both halves are held
    if (r_q.awv && r_q.wv && !r_q.bv) begin
      r_d.awv = 1'b0;
      r_d.wv = 1'b0;
      r_d.bv = 1'b1;
      r_d.bresp = RESP_OK;
      case ({r_q.awa[7:2], 2'b00})
        OFS_PSW: if (r_q.ws[0]) r_d.program_status_word = r_q.wd[7:0];
        // Memory control is frozen while an access runs
        OFS_AUX: if (r_q.ws[0] && r_q.st == S_IDLE) r_d.aux = r_q.wd[7:0];
        OFS_ADDR: begin
          if (r_q.ws[0]) r_d.addr[7:0] = r_q.wd[7:0];
          if (r_q.ws[1]) r_d.addr[15:8] = r_q.wd[15:8];
        end
        OFS_WDAT: if (r_q.ws[0]) r_d.wdat = r_q.wd[7:0];
        OFS_PORT2: if (r_q.ws[0]) r_d.port2 = r_q.wd[7:0];
        OFS_STAT: r_d.bresp = RESP_OK;
        OFS_CMD: begin
          // Start an access; ignored while one is running
          if (r_q.ws[0] && r_q.st == S_IDLE && r_q.wd[2:0] <= 3'h5) begin
            r_d.kind = dmx_kind_type'(r_q.wd[2:0]);
            r_d.wr = r_q.wd[CMD_WR];
            r_d.slow = r_q.aux[AUX_STRETCH];
            r_d.bitn = 3'h0;
            r_d.tgt = T_IRAM;
            r_d.st = S_IRD1;
            r_d.ma = {2'b00, r_q.addr[7:0]};
            case (dmx_kind_type'(r_q.wd[2:0]))
              K_DIRECT: begin
                // Direct upper half reaches special registers [RULE1] [RULE6]
                if (r_q.addr[7]) begin
                  r_d.tgt = T_SFR;
                end
              end
              // Indirect reaches all 256 bytes [RULE1] [RULE5]
              K_INDIRECT: r_d.tgt = T_IRAM;
              // Working register in the selected bank [RULE2] [RULE3]
              K_BANK: r_d.ma = {5'h00, r_q.program_status_word[PSW_BANK_LO+:2], r_q.addr[2:0]};
              K_BIT: begin
                r_d.bitn = r_q.addr[2:0];
                if (r_q.addr[7]) begin
                  r_d.tgt = T_SFR;
                  r_d.ma = {2'b00, r_q.addr[7:3], 3'b000};
                end else begin
                  // Bit area above the banks [RULE4]
                  r_d.ma = {6'h02, r_q.addr[6:3]};
                end
              end
              default: begin
                // Pointer-register form takes its high byte from port 2 [RULE18]
                xa = (dmx_kind_type'(r_q.wd[2:0]) == K_MOVX_RI) ?
                     {r_q.port2, r_q.addr[7:0]} : r_q.addr;
                r_d.ma = xa[9:0];
                // On-chip only when selected and within size [RULE7] [RULE8]
                if (!r_q.aux[AUX_EXT] && xa[15:10] == 6'h00 &&
                    xa[9:8] <= r_q.aux[AUX_SIZE_LO+:2]) begin // [RULE9] [RULE10]
                  r_d.tgt = T_EXPANDED_ON_CHIP_MEMORY;
                end else begin
                  // Out of range or deselected goes to the pins [RULE11]
                  r_d.tgt = T_EXT;
                  r_d.st = S_XADR;
                  r_d.ale = 1'b1;
                  r_d.p0o = xa[7:0];
                  r_d.p0oe = 1'b1;
                  r_d.p2o = (dmx_kind_type'(r_q.wd[2:0]) == K_MOVX_RI) ?
                            r_q.port2 : xa[15:8]; // [RULE12] [RULE18]
                end
              end
            endcase
            r_d.sa = r_d.ma[7:0];
            r_d.sre = (r_d.tgt == T_SFR);
          end
        end
        default: r_d.bresp = RESP_DEC;
      endcase
    end
    // Access sequencer
    case (r_q.st)
      S_IDLE: begin
        // Port 2 shows its latch; strobe runs free unless disabled [RULE19]
        if (r_d.st != S_XADR) begin
          r_d.p2o = r_q.port2;
          r_d.ale = !r_q.aux[AUX_DIS] && ale_pulse;
        end
      end
      S_IRD1: begin
        // Internal accesses leave the free-running strobe alone [RULE19]
        r_d.ale = !r_q.aux[AUX_DIS] && ale_pulse;
        r_d.st = S_IRD2;
      end
      S_IRD2: begin
        // Read byte, then write back the whole or merged byte
        case (r_q.tgt)
          T_SFR: r_d.rdat = sfr_rdata;
          T_EXPANDED_ON_CHIP_MEMORY: r_d.rdat = expanded_on_chip_memory_rd;
          default: r_d.rdat = iram_rd;
        endcase
        r_d.mwd = (r_q.kind == K_BIT) ? put_bit(r_d.rdat, r_q.bitn, r_q.wdat[0]) :
                  r_q.wdat;
        r_d.iwe = r_q.wr && r_q.tgt == T_IRAM;
        r_d.xwe = r_q.wr && r_q.tgt == T_EXPANDED_ON_CHIP_MEMORY;
        r_d.swe = r_q.wr && r_q.tgt == T_SFR;
        r_d.ale = !r_q.aux[AUX_DIS] && ale_pulse; // [RULE19]
        r_d.st = S_IDLE;
      end
      S_XADR: begin
        // Address held one more clock after the latch strobe falls [RULE13]
        r_d.ale = 1'b0;
        r_d.st = S_XLAT;
      end
      S_XLAT: begin
        // Strobe phase: write drives data, read releases port 0
        r_d.p0o = r_q.wdat;
        r_d.p0oe = r_q.wr; // [RULE15]
        r_d.rdn = r_q.wr; // [RULE14]
        r_d.wrn = !r_q.wr; // [RULE15]
        r_d.cnt = (r_q.slow ? STB_SLOW : STB_NORM) - 4'h1; // [RULE17]
        r_d.st = S_XSTB;
      end
      S_XSTB: begin
        if (r_q.cnt == 4'h0) begin
          // Sample read data at the last strobe clock [RULE14]
          if (!r_q.wr) begin
            r_d.rdat = muxed_low_addr_data_in;
          end
          r_d.rdn = 1'b1;
          r_d.wrn = 1'b1;
          r_d.st = S_XEND;
        end else begin
          r_d.cnt = r_q.cnt - 4'h1;
        end
      end
      S_XEND: begin
        // Last clock (sixth, or eighteenth when stretched): data hold, then bus released [RULE16]
        r_d.p0oe = 1'b0;
        r_d.st = S_IDLE;
      end
      default: r_d.st = S_IDLE;
    endcase
    // Ready flags follow the held slots
    r_d.awr = !r_d.awv;
    r_d.wr_rdy = !r_d.wv;
    r_d.arr = !r_d.rv;
    // Synchronous reset
    if (!rstn) begin
      r_d = '0;
      r_d.program_status_word = PSW_RST;
      r_d.aux = AUX_RST;
      r_d.port2 = PORT2_RST;
      r_d.p2o = PORT2_RST;
      r_d.ale = 1'b1;
      r_d.rdn = 1'b1;
      r_d.wrn = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    r_q <= r_d;
  end

  // Helper: length of the current strobe low time
  logic [4:0] low_len_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn || (r_q.rdn && r_q.wrn)) begin
      low_len_q <= 5'h00;
    end else begin
      low_len_q <= low_len_q + 5'h01;
    end
  end

  property p_bank_map; // [RULE3]
    @(posedge sys_clk) disable iff (!rstn)
    (r_q.st == S_IRD1 && r_q.kind == K_BANK) |->
      r_q.ma == {5'h00, r_q.program_status_word[4:3], r_q.addr[2:0]};
  endproperty
  a_bank_map: assert property (p_bank_map) else $error("bank register misplaced"); // [RULE3]

  property p_sfr_route; // [RULE6]
    @(posedge sys_clk) disable iff (!rstn)
    (r_q.st == S_IRD1 && r_q.kind == K_DIRECT && r_q.addr[7]) |-> r_q.sre && !r_q.iwe;
  endproperty
  a_sfr_route: assert property (p_sfr_route) else $error("direct high not to sfr"); // [RULE6]

  property p_expanded_on_chip_memory_sel; // [RULE11]
    @(posedge sys_clk) disable iff (!rstn)
    (r_q.st == S_IRD1 && r_q.tgt == T_EXPANDED_ON_CHIP_MEMORY) |->
      !r_q.aux[AUX_EXT] && r_q.ma[9:8] <= r_q.aux[3:2];
  endproperty
  a_expanded_on_chip_memory_sel: assert property (p_expanded_on_chip_memory_sel) else $error("on-chip memory wrong"); // [RULE11]

  property p_addr_phase; // [RULE13]
    @(posedge sys_clk) disable iff (!rstn)
    (r_q.st == S_XADR) |-> r_q.ale && r_q.p0oe ##1 !r_q.ale && r_q.p0oe && $stable(r_q.p0o);
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address phase wrong"); // [RULE13]

  property p_cycle_len; // [RULE16]
    @(posedge sys_clk) disable iff (!rstn)
    (r_q.st == S_XADR && !r_q.slow) |-> ##5 (r_q.st == S_XEND) ##1 (r_q.st == S_IDLE);
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("bus cycle not six clocks"); // [RULE16]

  property p_stb_width; // [RULE17]
    @(posedge sys_clk) disable iff (!rstn)
    $rose(r_q.rdn && r_q.wrn) |-> low_len_q == {1'b0, r_q.slow ? STB_SLOW : STB_NORM};
  endproperty
  a_stb_width: assert property (p_stb_width) else $error("strobe width wrong"); // [RULE17]

  property p_read_float; // [RULE14]
    @(posedge sys_clk) disable iff (!rstn)
    !r_q.rdn |-> !r_q.p0oe && r_q.wrn;
  endproperty
  a_read_float: assert property (p_read_float) else $error("port 0 driven in read"); // [RULE14]

  property p_write_data; // [RULE15]
    @(posedge sys_clk) disable iff (!rstn)
    !r_q.wrn |-> r_q.p0oe && r_q.p0o == r_q.wdat;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data not driven"); // [RULE15]

  property p_ri_port2; // [RULE18]
    @(posedge sys_clk) disable iff (!rstn)
    (r_q.st == S_XADR && r_q.kind == K_MOVX_RI) |-> r_q.p2o == r_q.port2;
  endproperty
  a_ri_port2: assert property (p_ri_port2) else $error("port 2 lost its latch"); // [RULE18]

  property p_ale_off; // [RULE19]
    @(posedge sys_clk) disable iff (!rstn)
    ($past(r_q.st) == S_IDLE && r_q.st == S_IDLE && r_q.aux[AUX_DIS] &&
     $past(r_q.aux[AUX_DIS])) |-> !r_q.ale;
  endproperty
  a_ale_off: assert property (p_ale_off) else $error("latch strobe while disabled"); // [RULE19]
endmodule
`default_nettype wire

//--- logic/dmx_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dmx_mem #(parameter int AW = 8) (
  // Clock
  input wire logic sys_clk,
  // Access port
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [7:0] wd,
  output logic [7:0] rd_q
);
  // Byte array, contents undefined at power-up
  logic [7:0] mem [0:(1<<AW)-1];
  // Registered read, write-through not needed
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wd;
    end
    rd_q <= mem[addr];
  end
endmodule
`default_nettype wire

//--- test/dmx_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dmx_core_tb_top import dmx_pkg::*; ;
  // Clock, reset and register bus
  logic sys_clk = 1'b0, rstn = 1'b0, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Special registers and external bus
  logic [7:0] sfr_addr_q, sfr_wdata_q, sfr_rdata = 8'h00, sfr_arr [0:255];
  logic sfr_rd_q, sfr_wr_q, muxed_low_addr_data_oe_q, ale_q, rd_n_q, wr_n_q;
  logic [7:0] muxed_low_addr_data_in, muxed_low_addr_data_out_q, upper_address_lines_q;
  // Bench state
  logic [31:0] st, v;
  logic [1:0] r;
  logic [15:0] a;
  logic [7:0] d, e;
  int b, n, seed, err_count = 0, checks = 0;
  int stb_run = 0, stb_w = 0, oe_run = 0, oe_w = 0, ale_cnt = 0, sfr_rd_cnt = 0;

  dmx_core dmx_core_inst (
    .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sfr_addr_q, .sfr_rd_q, .sfr_wr_q,
    .sfr_wdata_q, .sfr_rdata, .muxed_low_addr_data_in, .muxed_low_addr_data_out_q,
    .muxed_low_addr_data_oe_q, .upper_address_lines_q, .ale_q, .rd_n_q, .wr_n_q
  );
  dmx_ext_mem_model dmx_ext_mem_model_inst (
    .sys_clk, .p0_out(muxed_low_addr_data_out_q), .p0_oe(muxed_low_addr_data_oe_q),
    .p2(upper_address_lines_q), .ale(ale_q), .rd_n(rd_n_q), .wr_n(wr_n_q), .slow,
    .p0_wire(muxed_low_addr_data_in)
  );

  // Clock generator
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Special register stand-in, answers the cycle after the read pulse
  always @(posedge sys_clk) begin
    if (sfr_wr_q) sfr_arr[sfr_addr_q] <= sfr_wdata_q;
    if (sfr_rd_q) sfr_rd_cnt++;
    sfr_rdata <= sfr_arr[sfr_addr_q];
  end
  // Strobe, port 0 drive and latch pulse monitors
  always @(posedge sys_clk) begin
    if (!rd_n_q || !wr_n_q) stb_run++;
    else if (stb_run != 0) begin stb_w = stb_run; stb_run = 0; end
    if (muxed_low_addr_data_oe_q) oe_run++;
    else if (oe_run != 0) begin oe_w = oe_run; oe_run = 0; end
    if (ale_q) ale_cnt++;
  end

  // Verdict and end of run
  task automatic stop_test;
    $display("Counts: %0d comparisons, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A wait that ran out
  task automatic hang;
    err_count++;
    $display("Timeout at %0t", $time);
    stop_test();
  endtask
  // Data comparison
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus response comparison
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register write; called just after a rising edge
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    int k;
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 50) hang();
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Register read; called just after a rising edge
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int k;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 50) hang();
    dt = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // One memory access, then wait until no longer busy
  task automatic acc(input dmx_kind_type k, input logic [15:0] ad, input logic [7:0] dt,
    input logic wr);
    int i;
    axi_wr(OFS_ADDR, {16'h0, ad}, r);
    axi_wr(OFS_WDAT, {24'h0, dt}, r);
    axi_wr(OFS_CMD, {28'h0, wr, k}, r);
    for (i = 0; i < 40; i++) begin
      axi_rd(OFS_STAT, st, r);
      if (st[0] === 1'b0) break;
    end
    if (i == 40) hang();
  endtask
  // Status byte and target
  task automatic chk(input logic [7:0] dt, input logic [1:0] t);
    cmp_val(32'(st[15:8]), 32'(dt));
    cmp_val(32'(st[2:1]), 32'(t));
  endtask
  // Latch pulses over 30 cycles
  task automatic ale_chk(input int exp);
    @(negedge sys_clk) n = ale_cnt;
    repeat (30) @(negedge sys_clk);
    cmp_val(32'(ale_cnt - n), 32'(exp));
    @(posedge sys_clk);
  endtask
  // First byte beyond the on-chip size
  function automatic logic [15:0] xlim(input int s);
    return 16'((s + 1) * 256);
  endfunction

  initial begin
    seed = 36297;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    axi_rd(OFS_PSW, v, r);
    cmp_val(v, 32'(PSW_RST));
    cmp_resp(r, RESP_OK);
    axi_rd(OFS_AUX, v, r);
    cmp_val(v, 32'h0C);
    axi_rd(8'h1C, v, r);
    cmp_resp(r, RESP_DEC);
    axi_wr(8'h1C, 32'h0, r);
    cmp_resp(r, RESP_DEC);
    ale_chk(10);
    axi_wr(OFS_AUX, 32'h0D, r);
    cmp_resp(r, RESP_OK);
    ale_chk(0);
    $display("test reset and latch pulse done");
    repeat (4) begin
      a = 16'($random(seed)) & 16'h007F;
      d = 8'($random(seed));
      acc(K_DIRECT, a, d, 1'b1);
      acc(K_INDIRECT, a, 8'h00, 1'b0);
      chk(d, T_IRAM);
    end
    for (b = 0; b < 4; b++) begin
      axi_wr(OFS_PSW, 32'(b << PSW_BANK_LO), r);
      a = 16'($random(seed)) & 16'h0007;
      d = 8'($random(seed));
      acc(K_BANK, a, d, 1'b1);
      acc(K_DIRECT, 16'(b * 8) + a, 8'h00, 1'b0);
      chk(d, T_IRAM);
    end
    a = 16'($random(seed)) & 16'h007F;
    acc(K_DIRECT, 16'h20 + (a >> 3), 8'h00, 1'b1);
    acc(K_BIT, a, 8'h01, 1'b1);
    acc(K_BIT, a, 8'h00, 1'b0);
    cmp_val(32'(st[3]), 32'h1);
    acc(K_DIRECT, 16'h20 + (a >> 3), 8'h00, 1'b0);
    chk(8'h01 << a[2:0], T_IRAM);
    a = 16'h0080 | (16'($random(seed)) & 16'h007F);
    d = 8'($random(seed));
    e = ~d;
    acc(K_INDIRECT, a, d, 1'b1);
    acc(K_DIRECT, a, e, 1'b1);
    cmp_val(32'(st[2:1]), 32'(T_SFR));
    cmp_val(32'(sfr_rd_cnt), 32'h1);
    acc(K_INDIRECT, a, 8'h00, 1'b0);
    chk(d, T_IRAM);
    cmp_val(32'(sfr_arr[a[7:0]]), 32'(e));
    $display("test internal spaces done");
    for (b = 0; b < 4; b++) begin
      axi_wr(OFS_AUX, 32'(b << AUX_SIZE_LO), r);
      d = 8'($random(seed));
      acc(K_MOVX_DPTR, xlim(b) - 16'h1, d, 1'b1);
      acc(K_MOVX_DPTR, xlim(b), ~d, 1'b1);
      cmp_val(32'(st[2:1]), 32'(T_EXT));
      acc(K_MOVX_DPTR, xlim(b) - 16'h1, 8'h00, 1'b0);
      chk(d, T_EXPANDED_ON_CHIP_MEMORY);
    end
    axi_wr(OFS_AUX, 32'h0E, r);
    acc(K_MOVX_DPTR, 16'h0000, d, 1'b1);
    cmp_val(32'(st[2:1]), 32'(T_EXT));
    $display("test expanded memory done");
    for (b = 0; b < 2; b++) begin
      axi_wr(OFS_AUX, 32'h0F | 32'(b << AUX_STRETCH), r);
      slow <= b[0];
      a = 16'($random(seed));
      d = 8'($random(seed));
      e = 8'($random(seed));
      acc(K_MOVX_DPTR, a, d, 1'b1);
      cmp_val(32'(dmx_ext_mem_model_inst.mem[a]), 32'(d));
      cmp_val(32'(stb_w), b ? 32'd15 : 32'd3);
      cmp_val(32'(oe_w), b ? 32'd18 : 32'd6);
      acc(K_MOVX_DPTR, a, 8'h00, 1'b0);
      chk(d, T_EXT);
      cmp_val(32'(stb_w), b ? 32'd15 : 32'd3);
      axi_wr(OFS_PORT2, 32'(d), r);
      acc(K_MOVX_RI, {~d, a[7:0]}, e, 1'b1);
      cmp_val(32'(dmx_ext_mem_model_inst.mem[{d, a[7:0]}]), 32'(e));
    end
    $display("test external bus done");
    stop_test();
  end
endmodule
`default_nettype wire

//--- test/dmx_ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmx_ext_mem_model (
  // Clock
  input wire logic sys_clk,
  // Bus pins from the device
  input wire logic [7:0] p0_out,
  input wire logic p0_oe,
  input wire logic [7:0] p2,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  // Slow mode: data shows late in the strobe
  input wire logic slow,
  // Resolved level of port 0
  output logic [7:0] p0_wire
);
  logic [7:0] mem [0:65535]; // Whole external space
  logic [15:0] addr_q; // Latched address
  logic [7:0] last_q; // Last level seen on port 0
  logic [3:0] rd_cnt_q; // Cycles into the read strobe
  logic drv; // Model drives port 0
  // Drive only inside the read strobe, late when slow
  assign drv = !rd_n && (!slow || rd_cnt_q >= 4'h8);
  // Released line shows the inverse of the last level
  always_comb begin
    if (p0_oe) begin
      p0_wire = p0_out;
    end else if (drv) begin
      p0_wire = mem[addr_q];
    end else begin
      p0_wire = ~last_q;
    end
  end
  // Address capture, strobe count and write capture
  always_ff @(posedge sys_clk) begin
    last_q <= p0_wire;
    rd_cnt_q <= rd_n ? 4'h0 : rd_cnt_q + 4'h1;
    if (ale && p0_oe) begin
      addr_q <= {p2, p0_out};
    end
    if (!wr_n && p0_oe) begin
      mem[addr_q] <= p0_out;
    end
  end
endmodule
`default_nettype wire
